// File: rtl/dtc_defines.vh
// Register offsets, field positions, reset values and timing counts of the dual timer block
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// Register offsets in special-function register space
`define DTC_ADDR_RUN_FLAGS      8'h88
`define DTC_ADDR_MODE_SELECT    8'h89
`define DTC_ADDR_T0_LOW         8'h8a
`define DTC_ADDR_T1_LOW         8'h8b
`define DTC_ADDR_T0_HIGH        8'h8c
`define DTC_ADDR_T1_HIGH        8'h8d

// Reset values
`define DTC_RST_RUN_FLAGS       8'h00
`define DTC_RST_MODE_SELECT     8'h00
`define DTC_RST_COUNT           8'h00
`define DTC_RDATA_UNMAPPED      8'h00

// Fields of timer_run_and_irq_flags
`define DTC_BIT_T1_OVF          7
`define DTC_BIT_T1_RUN          6
`define DTC_BIT_T0_OVF          5
`define DTC_BIT_T0_RUN          4
`define DTC_BIT_X1_FLAG         3
`define DTC_BIT_X1_TYPE         2
`define DTC_BIT_X0_FLAG         1
`define DTC_BIT_X0_TYPE         0

// Fields of timer_mode_select
`define DTC_BIT_T1_GATE         7
`define DTC_BIT_T1_CSEL         6
`define DTC_MSB_T1_MODE         5
`define DTC_LSB_T1_MODE         4
`define DTC_BIT_T0_GATE         3
`define DTC_BIT_T0_CSEL         2
`define DTC_MSB_T0_MODE         1
`define DTC_LSB_T0_MODE         0

// Mode field encodings
`define DTC_MODE_PRESCALE       2'b00
`define DTC_MODE_SIXTEEN        2'b01
`define DTC_MODE_RELOAD         2'b10
`define DTC_MODE_SPLIT          2'b11

// Timer mode advances once per this many system clocks
`define DTC_TICK_CYCLES         2

// Pin index into the falling-edge detector
`define DTC_PIN_T0              0
`define DTC_PIN_T1              1
`define DTC_PIN_X0              2
`define DTC_PIN_X1              3
`define DTC_PIN_COUNT           4

// Acknowledge index for vectored interrupts
`define DTC_ACK_T0              0
`define DTC_ACK_T1              1
`define DTC_ACK_X0              2
`define DTC_ACK_X1              3

`endif

// File: rtl/dtc_fall_detect.v
// Falling-edge detector for a group of synchronous input pins
`timescale 1ns/1ps
module dtc_fall_detect #(
    parameter WIDTH = 4
) (
    // Clock, reset, enable
    input  wire             mclk,
    input  wire             srst,
    input  wire             ce,
    // Pins and edges
    input  wire [WIDTH-1:0] pin,
    output wire [WIDTH-1:0] fall
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
            reg prev;
            // Cleared at reset so a pin already low is not taken as an edge
            always @(posedge mclk) begin
                if (srst) begin
                    prev <= 1'b0;
                end else if (ce) begin
                    prev <= pin[g];
                end
            end
            assign fall[g] = ce & prev & ~pin[g];
        end
    endgenerate

endmodule // dtc_fall_detect

// File: rtl/dtc_timer_core.v
// Next-count and overflow logic of one timer pair in all four modes
`timescale 1ns/1ps
`include "dtc_defines.vh"
module dtc_timer_core (
    // Configuration
    input  wire [1:0] mode,
    // Present count
    input  wire [7:0] cnt_lo,
    input  wire [7:0] cnt_hi,
    // Count steps
    input  wire       step_lo,
    input  wire       step_hi,
    // Result
    output reg  [7:0] next_lo,
    output reg  [7:0] next_hi,
    output reg        wrap_lo,
    output reg        wrap_hi
);

    reg [12:0] pre_sum;
    reg [15:0] wide_sum;

    always @* begin
        pre_sum  = 13'h0000;
        wide_sum = 16'h0000;
        next_lo  = cnt_lo;
        next_hi  = cnt_hi;
        wrap_lo  = 1'b0;
        wrap_hi  = 1'b0;
        case (mode)
            `DTC_MODE_PRESCALE: begin
                // Low five bits carry into the high byte; upper low bits hold
                pre_sum = {cnt_hi, cnt_lo[4:0]} + 13'h0001;
                if (step_lo) begin
                    next_lo = {cnt_lo[7:5], pre_sum[4:0]};
                    next_hi = pre_sum[12:5];
                    wrap_lo = &{cnt_hi, cnt_lo[4:0]};
                end
            end
            `DTC_MODE_SIXTEEN: begin
                wide_sum = {cnt_hi, cnt_lo} + 16'h0001;
                if (step_lo) begin
                    next_lo = wide_sum[7:0];
                    next_hi = wide_sum[15:8];
                    wrap_lo = &{cnt_hi, cnt_lo};
                end
            end
            `DTC_MODE_RELOAD: begin
                if (step_lo) begin
                    wrap_lo = &cnt_lo;
                    next_lo = (&cnt_lo) ? cnt_hi : cnt_lo + 8'h01;
                end
            end
            `DTC_MODE_SPLIT: begin
                // Two independent bytes, each with its own step and wrap
                if (step_lo) begin
                    next_lo = cnt_lo + 8'h01;
                    wrap_lo = &cnt_lo;
                end
                if (step_hi) begin
                    next_hi = cnt_hi + 8'h01;
                    wrap_hi = &cnt_hi;
                end
            end
            default: begin
                next_lo = cnt_lo;
                next_hi = cnt_hi;
            end
        endcase
    end

endmodule // dtc_timer_core

// File: rtl/dtc_top.v
// Dual timer/counter with external interrupt pin detection and its register file
`timescale 1ns/1ps
`include "dtc_defines.vh"
module dtc_top (
    // Clock, reset, enable
    input  wire       mclk,
    input  wire       srst,
    input  wire       ce,
    // Special-function register port
    input  wire [7:0] sfr_addr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_wr,
    input  wire       sfr_rd,
    output reg  [7:0] sfr_rdata,
    // Interrupt vector acknowledges, one per source
    input  wire [3:0] irq_ack,
    // External pins
    input  wire       timer_zero_count_pin,
    input  wire       timer_one_count_pin,
    input  wire       ext_irq_zero_pin,
    input  wire       ext_irq_one_pin,
    // Interrupt requests
    output reg        timer_zero_overflow_flag,
    output reg        timer_one_overflow_flag,
    output reg        ext_irq_zero_flag,
    output reg        ext_irq_one_flag
);

    // Registers
    reg  [7:0] timer_run_and_irq_flags;
    reg  [7:0] timer_mode_select;
    reg  [7:0] timer_zero_count_low;
    reg  [7:0] timer_zero_count_high;
    reg  [7:0] timer_one_count_low;
    reg  [7:0] timer_one_count_high;
    reg        tick_phase;

    // Fields
    wire       timer_one_run;
    wire       timer_zero_run;
    wire       ext_irq_one_type;
    wire       ext_irq_zero_type;
    wire       timer_one_pin_gating;
    wire       timer_zero_pin_gating;
    wire       timer_one_counter_select;
    wire       timer_zero_counter_select;
    wire [1:0] timer_one_mode_field;
    wire [1:0] timer_zero_mode_field;

    // Count path
    wire [3:0] pin_fall;
    wire       tick;
    wire       t0_split;
    wire       t0_enable;
    wire       t1_enable;
    wire       t0_step;
    wire       t1_step;
    wire       t0_high_step;
    wire [7:0] t0_next_lo;
    wire [7:0] t0_next_hi;
    wire [7:0] t1_next_lo;
    wire [7:0] t1_next_hi;
    wire       t0_wrap_lo;
    wire       t0_wrap_hi;
    wire       t1_wrap_lo;
    wire       t1_wrap_hi;
    wire       t0_ovf_set;
    wire       t1_ovf_set;
    wire       x0_set;
    wire       x1_set;

    // Write strobes
    wire       wr_flags;
    wire       wr_mode;
    wire       wr_t0_lo;
    wire       wr_t0_hi;
    wire       wr_t1_lo;
    wire       wr_t1_hi;
    reg  [7:0] next_flags;
    reg  [7:0] next_rdata;

    // Vector acknowledges
    wire       ack_t0;
    wire       ack_t1;
    wire       ack_x0;
    wire       ack_x1;

    // Next count bytes
    wire [7:0] next_t0_lo;
    wire [7:0] next_t0_hi;
    wire [7:0] next_t1_lo;
    wire [7:0] next_t1_hi;

    assign timer_one_run             = timer_run_and_irq_flags[`DTC_BIT_T1_RUN];
    assign timer_zero_run            = timer_run_and_irq_flags[`DTC_BIT_T0_RUN];
    assign ext_irq_one_type          = timer_run_and_irq_flags[`DTC_BIT_X1_TYPE];
    assign ext_irq_zero_type         = timer_run_and_irq_flags[`DTC_BIT_X0_TYPE];
    assign timer_one_pin_gating      = timer_mode_select[`DTC_BIT_T1_GATE];
    assign timer_zero_pin_gating     = timer_mode_select[`DTC_BIT_T0_GATE];
    assign timer_one_counter_select  = timer_mode_select[`DTC_BIT_T1_CSEL];
    assign timer_zero_counter_select = timer_mode_select[`DTC_BIT_T0_CSEL];
    assign timer_one_mode_field      = timer_mode_select[`DTC_MSB_T1_MODE:`DTC_LSB_T1_MODE];
    assign timer_zero_mode_field     = timer_mode_select[`DTC_MSB_T0_MODE:`DTC_LSB_T0_MODE];

    assign wr_flags = ce & sfr_wr & (sfr_addr == `DTC_ADDR_RUN_FLAGS);
    assign wr_mode  = ce & sfr_wr & (sfr_addr == `DTC_ADDR_MODE_SELECT);
    assign wr_t0_lo = ce & sfr_wr & (sfr_addr == `DTC_ADDR_T0_LOW);
    assign wr_t0_hi = ce & sfr_wr & (sfr_addr == `DTC_ADDR_T0_HIGH);
    assign wr_t1_lo = ce & sfr_wr & (sfr_addr == `DTC_ADDR_T1_LOW);
    assign wr_t1_hi = ce & sfr_wr & (sfr_addr == `DTC_ADDR_T1_HIGH);

    dtc_fall_detect #(
        .WIDTH (`DTC_PIN_COUNT)
    ) u_fall (
        .mclk (mclk),
        .srst (srst),
        .ce   (ce),
        .pin  ({ext_irq_one_pin, ext_irq_zero_pin, timer_one_count_pin, timer_zero_count_pin}),
        .fall (pin_fall)
    );

    // Divide-by-two tick; only a divider of exactly two is supported here
    always @(posedge mclk) begin
        if (srst) begin
            tick_phase <= 1'b0;
        end else if (ce) begin
            tick_phase <= ~tick_phase;
        end
    end
    assign tick = ce & tick_phase;

    assign t0_split  = (timer_zero_mode_field == `DTC_MODE_SPLIT);
    assign t0_enable = timer_zero_run & (~timer_zero_pin_gating | ext_irq_zero_pin);
    assign t1_enable = timer_one_run & (~timer_one_pin_gating | ext_irq_one_pin);

    assign t0_step = t0_enable
                   & (timer_zero_counter_select ? pin_fall[`DTC_PIN_T0] : tick);
    // Mode three holds timer one still
    assign t1_step = t1_enable & (timer_one_mode_field != `DTC_MODE_SPLIT)
                   & (timer_one_counter_select ? pin_fall[`DTC_PIN_T1] : tick);
    // Split high byte is a plain timer run by timer one's run bit
    assign t0_high_step = t0_split & timer_one_run & tick;

    dtc_timer_core u_core0 (
        .mode    (timer_zero_mode_field),
        .cnt_lo  (timer_zero_count_low),
        .cnt_hi  (timer_zero_count_high),
        .step_lo (t0_step),
        .step_hi (t0_high_step),
        .next_lo (t0_next_lo),
        .next_hi (t0_next_hi),
        .wrap_lo (t0_wrap_lo),
        .wrap_hi (t0_wrap_hi)
    );

    dtc_timer_core u_core1 (
        .mode    (timer_one_mode_field),
        .cnt_lo  (timer_one_count_low),
        .cnt_hi  (timer_one_count_high),
        .step_lo (t1_step),
        .step_hi (1'b0),
        .next_lo (t1_next_lo),
        .next_hi (t1_next_hi),
        .wrap_lo (t1_wrap_lo),
        .wrap_hi (t1_wrap_hi)
    );

    assign t0_ovf_set = t0_wrap_lo;
    // While timer zero is split, its high byte owns timer one's flag
    assign t1_ovf_set = t0_split ? t0_wrap_hi : (t1_wrap_lo | t1_wrap_hi);
    assign x0_set     = ext_irq_zero_type ? pin_fall[`DTC_PIN_X0] : ~ext_irq_zero_pin;
    assign x1_set     = ext_irq_one_type ? pin_fall[`DTC_PIN_X1] : ~ext_irq_one_pin;

    // One acknowledge per flag, raised by the processor as it vectors
    assign ack_t0 = irq_ack[`DTC_ACK_T0];
    assign ack_t1 = irq_ack[`DTC_ACK_T1];
    assign ack_x0 = irq_ack[`DTC_ACK_X0];
    assign ack_x1 = irq_ack[`DTC_ACK_X1];

    // Order: software write, then vector clear, then hardware set wins
    always @* begin
        next_flags = wr_flags ? sfr_wdata : timer_run_and_irq_flags;
        if (ack_t1) begin
            next_flags[`DTC_BIT_T1_OVF] = 1'b0;
        end
        if (ack_t0) begin
            next_flags[`DTC_BIT_T0_OVF] = 1'b0;
        end
        if (ack_x1) begin
            next_flags[`DTC_BIT_X1_FLAG] = 1'b0;
        end
        if (ack_x0) begin
            next_flags[`DTC_BIT_X0_FLAG] = 1'b0;
        end
        // Level type follows the pin, so a released pin withdraws its request
        if (!ext_irq_one_type) begin
            next_flags[`DTC_BIT_X1_FLAG] = 1'b0;
        end
        if (!ext_irq_zero_type) begin
            next_flags[`DTC_BIT_X0_FLAG] = 1'b0;
        end
        if (t1_ovf_set) begin
            next_flags[`DTC_BIT_T1_OVF] = 1'b1;
        end
        if (t0_ovf_set) begin
            next_flags[`DTC_BIT_T0_OVF] = 1'b1;
        end
        if (x1_set) begin
            next_flags[`DTC_BIT_X1_FLAG] = 1'b1;
        end
        if (x0_set) begin
            next_flags[`DTC_BIT_X0_FLAG] = 1'b1;
        end
    end

    always @* begin
        case (sfr_addr)
            `DTC_ADDR_RUN_FLAGS:   next_rdata = timer_run_and_irq_flags;
            `DTC_ADDR_MODE_SELECT: next_rdata = timer_mode_select;
            `DTC_ADDR_T0_LOW:      next_rdata = timer_zero_count_low;
            `DTC_ADDR_T1_LOW:      next_rdata = timer_one_count_low;
            `DTC_ADDR_T0_HIGH:     next_rdata = timer_zero_count_high;
            `DTC_ADDR_T1_HIGH:     next_rdata = timer_one_count_high;
            default:               next_rdata = `DTC_RDATA_UNMAPPED;
        endcase
    end

    // A byte write overrides the count step of the same cycle
    assign next_t0_lo = wr_t0_lo ? sfr_wdata : t0_next_lo;
    assign next_t0_hi = wr_t0_hi ? sfr_wdata : t0_next_hi;
    assign next_t1_lo = wr_t1_lo ? sfr_wdata : t1_next_lo;
    assign next_t1_hi = wr_t1_hi ? sfr_wdata : t1_next_hi;

    // Register and flag outputs share one edge, so a read never disagrees with a pin
    always @(posedge mclk) begin
        if (srst) begin
            timer_run_and_irq_flags  <= `DTC_RST_RUN_FLAGS;
            timer_zero_overflow_flag <= 1'b0;
            timer_one_overflow_flag  <= 1'b0;
            ext_irq_zero_flag        <= 1'b0;
            ext_irq_one_flag         <= 1'b0;
        end else if (ce) begin
            timer_run_and_irq_flags  <= next_flags;
            timer_zero_overflow_flag <= next_flags[`DTC_BIT_T0_OVF];
            timer_one_overflow_flag  <= next_flags[`DTC_BIT_T1_OVF];
            ext_irq_zero_flag        <= next_flags[`DTC_BIT_X0_FLAG];
            ext_irq_one_flag         <= next_flags[`DTC_BIT_X1_FLAG];
        end
    end

    // Mode bits change only by software; no hardware source touches them
    always @(posedge mclk) begin
        if (srst) begin
            timer_mode_select <= `DTC_RST_MODE_SELECT;
        end else if (wr_mode) begin
            timer_mode_select <= sfr_wdata;
        end
    end

    // All four count bytes step and load on the same edge
    always @(posedge mclk) begin
        if (srst) begin
            timer_zero_count_low  <= `DTC_RST_COUNT;
            timer_zero_count_high <= `DTC_RST_COUNT;
            timer_one_count_low   <= `DTC_RST_COUNT;
            timer_one_count_high  <= `DTC_RST_COUNT;
        end else if (ce) begin
            timer_zero_count_low  <= next_t0_lo;
            timer_zero_count_high <= next_t0_hi;
            timer_one_count_low   <= next_t1_lo;
            timer_one_count_high  <= next_t1_hi;
        end
    end

    // Read data is held between reads; a 16-bit pair read byte by byte can tear
    always @(posedge mclk) begin
        if (srst) begin
            sfr_rdata <= `DTC_RDATA_UNMAPPED;
        end else if (ce && sfr_rd) begin
            sfr_rdata <= next_rdata;
        end
    end

endmodule // dtc_top

// File: tb/dtc_checker.sv
// Port-level assertions for the dual timer block
`timescale 1ns/1ps
module dtc_checker (
    // Clock and reset
    input wire       mclk,
    input wire       srst,
    input wire       ce,
    // Register port
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire       sfr_wr,
    input wire       sfr_rd,
    input wire [7:0] sfr_rdata,
    input wire [3:0] irq_ack,
    // Pins and flags
    input wire       ext_irq_zero_pin,
    input wire       ext_irq_one_pin,
    input wire       timer_zero_overflow_flag,
    input wire       timer_one_overflow_flag,
    input wire       ext_irq_zero_flag,
    input wire       ext_irq_one_flag
);
    // Shadow of the control register, only run and type bits are trusted
    reg  [7:0] ctl;
    wire       wr_ctl = ce && sfr_wr && sfr_addr == 8'h88;
    always @(posedge mclk)
        if (srst) ctl <= 8'h00;
        else if (wr_ctl) ctl <= sfr_wdata;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_x0_level;
        ce && !ctl[0] |=> ext_irq_zero_flag == !$past(ext_irq_zero_pin);
    endproperty
    a_x0_level: assert property (p_x0_level)
        else $error("zero level flag wrong");
    property p_x1_level;
        ce && !ctl[2] |=> ext_irq_one_flag == !$past(ext_irq_one_pin);
    endproperty
    a_x1_level: assert property (p_x1_level)
        else $error("one level flag wrong");
    // History is cleared by reset, so the cycle after release is skipped
    property p_x0_edge;
        ce && $past(ce) && !$past(srst) && ctl[0] && $past(ext_irq_zero_pin)
            && !ext_irq_zero_pin |=> ext_irq_zero_flag;
    endproperty
    a_x0_edge: assert property (p_x0_edge)
        else $error("zero edge flag not set");
    property p_x1_edge;
        ce && $past(ce) && !$past(srst) && ctl[2] && $past(ext_irq_one_pin)
            && !ext_irq_one_pin |=> ext_irq_one_flag;
    endproperty
    a_x1_edge: assert property (p_x1_edge)
        else $error("one edge flag not set");
    property p_x0_ack;
        ce && ctl[0] && irq_ack[2] && !wr_ctl && ext_irq_zero_pin |=> !ext_irq_zero_flag;
    endproperty
    a_x0_ack: assert property (p_x0_ack)
        else $error("zero edge flag not cleared");
    property p_t1_ack;
        ce && irq_ack[1] && !wr_ctl && !ctl[6] |=> !timer_one_overflow_flag;
    endproperty
    a_t1_ack: assert property (p_t1_ack)
        else $error("timer one flag not cleared");
    property p_t0_run;
        $rose(timer_zero_overflow_flag) |-> $past(ctl[4]) || $past(wr_ctl);
    endproperty
    a_t0_run: assert property (p_t0_run)
        else $error("timer zero flag while stopped");
    property p_t1_run;
        $rose(timer_one_overflow_flag) |-> $past(ctl[6]) || $past(wr_ctl);
    endproperty
    a_t1_run: assert property (p_t1_run)
        else $error("timer one flag while stopped");
    property p_rd_ctl;
        ce && sfr_rd && sfr_addr == 8'h88 |=> sfr_rdata[7] == $past(timer_one_overflow_flag)
            && sfr_rdata[5] == $past(timer_zero_overflow_flag)
            && sfr_rdata[3] == $past(ext_irq_one_flag) && sfr_rdata[1] == $past(ext_irq_zero_flag);
    endproperty
    a_rd_ctl: assert property (p_rd_ctl)
        else $error("control read flags wrong");
    property p_rd_unmapped;
        ce && sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8d) |=> sfr_rdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");
    // With the clock enable low nothing the processor can see may move
    property p_ce_hold;
        !ce |=> $stable({sfr_rdata, timer_zero_overflow_flag, timer_one_overflow_flag,
            ext_irq_zero_flag, ext_irq_one_flag});
    endproperty
    a_ce_hold: assert property (p_ce_hold)
        else $error("state moved while clock enable low");
    c_t0_ovf: cover property ($rose(timer_zero_overflow_flag));
    c_split: cover property (ctl[6] && !ctl[4] && $rose(timer_one_overflow_flag));
    c_t1_ovf: cover property ($rose(timer_one_overflow_flag));
    c_x0_edge: cover property (ctl[0] && $rose(ext_irq_zero_flag));
endmodule // dtc_checker

bind dtc_top dtc_checker u_chk (
    .mclk(mclk), .srst(srst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .irq_ack(irq_ack),
    .ext_irq_zero_pin(ext_irq_zero_pin), .ext_irq_one_pin(ext_irq_one_pin),
    .timer_zero_overflow_flag(timer_zero_overflow_flag),
    .timer_one_overflow_flag(timer_one_overflow_flag),
    .ext_irq_zero_flag(ext_irq_zero_flag), .ext_irq_one_flag(ext_irq_one_flag));

// File: tb/dtc_pin_model.sv
// Behavioural model of the count and interrupt pins
`timescale 1ns/1ps
module dtc_pin_model (
    // Clock
    input  wire       mclk,
    // Levels asked for by the bench
    input  wire [3:0] level,
    // Pins
    output reg  [3:0] pin
);
    // Pins idle high so a first low is a real falling edge
    initial pin = 4'hf;
    always @(negedge mclk)
        pin <= level;
endmodule // dtc_pin_model

// File: tb/tb_dtc_top.sv
// Self-checking bench of the dual timer block
`timescale 1ns/1ps
module tb_dtc_top;
    reg         mclk, srst, ce, sfr_wr, sfr_rd;
    reg  [7:0]  sfr_addr, sfr_wdata;
    reg  [3:0]  irq_ack, level;
    reg  [31:0] rnd;
    wire [7:0]  sfr_rdata;
    wire [3:0]  pin, flag;
    integer     n_errors, check_count, seed, i, j, k;
    dtc_pin_model pins (.mclk(mclk), .level(level), .pin(pin));
    dtc_top dut (.mclk(mclk), .srst(srst), .ce(ce), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .irq_ack(irq_ack), .timer_zero_count_pin(pin[0]), .timer_one_count_pin(pin[1]),
        .ext_irq_zero_pin(pin[2]), .ext_irq_one_pin(pin[3]),
        .timer_zero_overflow_flag(flag[0]), .timer_one_overflow_flag(flag[1]),
        .ext_irq_zero_flag(flag[2]), .ext_irq_one_flag(flag[3]));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Expected {overflow, high, low} after n count steps
    function [16:0] model(input [1:0] m, input t, input [15:0] v, input integer n);
        integer    s;
        reg [16:0] x;
        reg [12:0] c;
        begin
            x = {1'b0, v};
            for (s = 0; s < n; s = s + 1) begin
                c = {x[15:8], x[4:0]} + 13'h1;
                if (m == 2'b00 ? c == 13'h0 : m == 2'b01 ? &x[15:0] : !(m[0] && t) && &x[7:0])
                    x[16] = 1'b1;
                case (m)
                    2'b00: {x[15:8], x[4:0]} = c;
                    2'b01: x[15:0] = x[15:0] + 16'h1;
                    2'b10: x[7:0] = &x[7:0] ? x[15:8] : x[7:0] + 8'h1;
                    default: x[7:0] = t ? x[7:0] : x[7:0] + 8'h1;
                endcase
            end
            model = x;
        end
    endfunction
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge mclk);
            sfr_addr <= a;
            sfr_wdata <= d;
            sfr_wr <= 1'b1;
            @(negedge mclk);
            sfr_wr <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            @(negedge mclk);
            sfr_addr <= a;
            sfr_rd <= 1'b1;
            @(negedge mclk);
            sfr_rd <= 1'b0;
            cmp(sfr_rdata, exp);
        end
    endtask
    task ack(input [1:0] s);
        begin
            @(negedge mclk);
            irq_ack <= 4'h1 << s;
            @(negedge mclk);
            irq_ack <= 4'h0;
        end
    endtask
    // Counting is stopped by gating with the pin held low, so the flag is not overwritten
    task tcase(input t, input [1:0] m, input [1:0] g, input integer n, input [15:0] v);
        reg [7:0]  nib;
        reg [16:0] e;
        begin
            nib = {4'h0, g, m};
            wr(8'h88, 8'h05);
            wr(8'h89, t ? nib << 4 : nib);
            wr(t ? 8'h8d : 8'h8c, v[15:8]);
            wr(t ? 8'h8b : 8'h8a, v[7:0]);
            level[2 + t] <= 1'b0;
            e = model(m, t, v, g[0] ? n : g[1] ? 0 : n + 1);
            wr(8'h88, t ? 8'h45 : 8'h15);
            for (k = 0; k < n; k = k + 1) begin
                level[t] <= ~g[0];
                @(negedge mclk);
                level[t] <= 1'b1;
                @(negedge mclk);
            end
            wr(8'h89, t ? (nib | 8'h08) << 4 : nib | 8'h08);
            rdc(t ? 8'h8d : 8'h8c, e[15:8]);
            rdc(t ? 8'h8b : 8'h8a, e[7:0]);
            cmp({7'h0, flag[t]}, {7'h0, e[16]});
            wr(8'h88, 8'h05 | (e[16] ? (t ? 8'h80 : 8'h20) : 8'h00));
            ack({1'b0, t});
            cmp({7'h0, flag[t]}, 8'h00);
            level[2 + t] <= 1'b1;
        end
    endtask
    task results;
        begin
            $display("errors=%0d checks=%0d", n_errors, check_count);
            if (n_errors == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        #2_000_000;
        n_errors = n_errors + 1;
        results;
    end
    initial begin
        {srst, ce, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_ack} = {2'b11, 22'h0};
        level = 4'hf;
        n_errors = 0;
        check_count = 0;
        seed = 75;
        repeat (12) @(negedge mclk);
        srst <= 1'b0;
        for (i = 8'h87; i < 8'h8f; i = i + 1)
            rdc(i[7:0], 8'h00);
        for (i = 8'h8a; i < 8'h8e; i = i + 1) begin
            rnd = $random(seed);
            wr(i[7:0], rnd[7:0]);
            rdc(i[7:0], rnd[7:0]);
        end
        $display("registers done");
        for (i = 0; i < 32; i = i + 1) begin
            rnd = $random(seed);
            tcase(i[0], i[2:1], &i[4:3] ? 2'b00 : i[4:3], 1 + rnd[18:16],
                &i[4:3] ? 16'hfffd : rnd[15:0]);
        end
        $display("timers done");
        // Split: timer zero high byte runs on timer one's run bit, 6 edges give 3 ticks
        wr(8'h89, 8'h33);
        wr(8'h8c, 8'hfe);
        wr(8'h88, 8'h45);
        repeat (4) @(negedge mclk);
        cmp({6'h0, flag[1:0]}, 8'h02);
        wr(8'h89, 8'h30);
        rdc(8'h8c, 8'h01);
        // Clock enable low for 10 edges; only the 2 enabled edges give a tick
        wr(8'h8a, 8'h00);
        wr(8'h89, 8'h31);
        wr(8'h88, 8'h15);
        ce <= 1'b0;
        repeat (10) @(negedge mclk);
        ce <= 1'b1;
        wr(8'h88, 8'h05);
        rdc(8'h8a, 8'h01);
        $display("split and enable done");
        for (j = 0; j < 2; j = j + 1) begin
            wr(8'h88, 8'h05);
            rdc(8'h88, 8'h05);
            level[2 + j] <= 1'b0;
            repeat (3) @(negedge mclk);
            cmp({7'h0, flag[2 + j]}, 8'h01);
            level[2 + j] <= 1'b1;
            repeat (3) @(negedge mclk);
            cmp({7'h0, flag[2 + j]}, 8'h01);
            ack(2 + j);
            cmp({7'h0, flag[2 + j]}, 8'h00);
            wr(8'h88, 8'h00);
            level[2 + j] <= 1'b0;
            repeat (3) @(negedge mclk);
            cmp({7'h0, flag[2 + j]}, 8'h01);
            level[2 + j] <= 1'b1;
            repeat (3) @(negedge mclk);
            cmp({7'h0, flag[2 + j]}, 8'h00);
        end
        $display("interrupt pins done");
        results;
    end
endmodule // tb_dtc_top
